// File: design/fault_protection_regs.vh
// Constants, register map and timing counts for the inverter fault protection block.
`ifndef FAULT_PROTECTION_REGS_VH
`define FAULT_PROTECTION_REGS_VH

`define CLK_PERIOD_NS 25
`define CYC_UP(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define OVERCUR_BLANK_NS 370
`define OVERCUR_DELAY_NS 300
`define SHORTCKT_BLANK_NS 810
`define SHORTCKT_DELAY_NS 900
`define LINE_FILTER_NS 300
`define OVERLAP_FILTER_NS 800
`define FAULT_HOLD_MS 10

`define OVERCUR_BLANK_CYC `CYC_UP(`OVERCUR_BLANK_NS)
`define OVERCUR_DELAY_CYC `CYC_UP(`OVERCUR_DELAY_NS)
`define SHORTCKT_BLANK_CYC `CYC_UP(`SHORTCKT_BLANK_NS)
`define SHORTCKT_DELAY_CYC `CYC_UP(`SHORTCKT_DELAY_NS)
`define LINE_FILTER_CYC `CYC_UP(`LINE_FILTER_NS)
`define OVERLAP_FILTER_CYC `CYC_UP(`OVERLAP_FILTER_NS)
`define FAULT_HOLD_CYC ((`FAULT_HOLD_MS * 1000000) / `CLK_PERIOD_NS)

`define REG_STATUS 2'h0
`define REG_MASK 2'h1
`define REG_LIVE 2'h2
`define MASK_RESET 9'h000
`define SYNC_RESET 16'h0E00

`define EV_OVERCUR_U 0
`define EV_OVERCUR_W 1
`define EV_SHORTCKT_V 2
`define EV_OVERLAP_U 3
`define EV_OVERLAP_V 4
`define EV_OVERLAP_W 5
`define EV_THERMAL_U 6
`define EV_THERMAL_W 7
`define EV_EXTERNAL 8
`define EV_COUNT 9

`endif

// File: design/persist_filter.v
// Persistence filter: output high once the input has stayed high for a set count.
`timescale 1ns/1ps
module persist_filter #(
   parameter COUNT = 8
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Level in and filtered level out
   input wire level,
   output wire held
);
   reg [7:0] cntQ;
   reg [7:0] cntD;

   always @* begin
      cntD = cntQ;
      if (!level) begin
         cntD = 8'h00;
      end else if (cntQ != COUNT[7:0]) begin
         cntD = cntQ + 8'h01;
      end
   end

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         cntQ <= 8'h00;
      end else begin
         cntQ <= cntD;
      end
   end

   // Release is immediate; only the onset is filtered.
   assign held = (cntQ == COUNT[7:0]);
endmodule

// File: design/inverter_fault_protection.v
// Three-phase gate fault protection with an Avalon-MM status and interrupt port.
//
// Local design decisions: the register addresses and register access over Avalon-MM.
`timescale 1ns/1ps
`include "fault_protection_regs.vh"
module inverter_fault_protection #(
   parameter HOLD_CYCLES = `FAULT_HOLD_CYC
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Comparator inputs from the analog front end
   input wire overcurrentSenseU,
   input wire overcurrentSenseW,
   input wire lowsideSenseV,
   input wire [1:0] tempAboveTrip,
   input wire [1:0] tempAboveRelease,
   // Commands, index 0 U, 1 V, 2 W
   input wire [2:0] highCommandIn,
   input wire [2:0] lowCommandIn,
   // Gate outputs
   output wire [2:0] highGateOut,
   output wire [2:0] lowGateOut,
   // Open-drain fault pins
   input wire faultLineUIn,
   input wire faultLineVIn,
   input wire faultLineWIn,
   output wire faultLineUOut,
   output wire faultLineVOut,
   output wire faultLineWOut,
   output wire faultLineUOeN,
   output wire faultLineVOeN,
   output wire faultLineWOeN,
   // Avalon-MM slave
   input wire [3:0] address,
   input wire read,
   input wire write,
   input wire [31:0] writedata,
   output wire [31:0] readdata,
   output wire waitrequest,
   // Interrupt
   output wire irq
);
   localparam ST_IDLE = 2'h0;
   localparam ST_DELAY = 2'h1;
   localparam ST_HOLD = 2'h2;
   localparam [19:0] OC_DELAY = `OVERCUR_DELAY_CYC;
   localparam [19:0] SC_DELAY = `SHORTCKT_DELAY_CYC;
   localparam [19:0] HOLD_LEN = HOLD_CYCLES;

   ////////////////////////////////////////////////////////////////////////////
   // Input synchronisers.

   wire [15:0] rawIn;
   reg [15:0] sync1Q;
   reg [15:0] sync2Q;

   assign rawIn = {tempAboveRelease, tempAboveTrip, faultLineWIn, faultLineVIn,
      faultLineUIn, lowCommandIn, highCommandIn, lowsideSenseV, overcurrentSenseW,
      overcurrentSenseU};

   // Fault wires reset to their pulled-up idle level, so no false event follows reset.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1Q <= `SYNC_RESET;
         sync2Q <= `SYNC_RESET;
      end else begin
         sync1Q <= rawIn;
         sync2Q <= sync1Q;
      end
   end

   wire ocU = sync2Q[0];
   wire ocW = sync2Q[1];
   wire scV = sync2Q[2];
   wire [2:0] cmdHigh = sync2Q[5:3];
   wire [2:0] cmdLow = sync2Q[8:6];
   wire [2:0] lineIn = sync2Q[11:9];
   wire [1:0] hotTrip = sync2Q[13:12];
   wire [1:0] hotRelease = sync2Q[15:14];

   ////////////////////////////////////////////////////////////////////////////
   // Blanking and noise filters.

   wire [2:0] armed;
   wire [2:0] overlap;
   wire lineLowV;

   persist_filter #(.COUNT(`OVERCUR_BLANK_CYC)) blankU (
      .clk(clk),
      .rst(rst),
      .level(ocU),
      .held(armed[0])
   );

   persist_filter #(.COUNT(`OVERCUR_BLANK_CYC)) blankW (
      .clk(clk),
      .rst(rst),
      .level(ocW),
      .held(armed[1])
   );

   persist_filter #(.COUNT(`SHORTCKT_BLANK_CYC)) blankV (
      .clk(clk),
      .rst(rst),
      .level(scV),
      .held(armed[2])
   );

   persist_filter #(.COUNT(`LINE_FILTER_CYC)) lineFilterV (
      .clk(clk),
      .rst(rst),
      .level(~lineIn[1]),
      .held(lineLowV)
   );

   genvar p;
   generate
      for (p = 0; p < 3; p = p + 1) begin : phase
         persist_filter #(.COUNT(`OVERLAP_FILTER_CYC)) overlapFilter (
            .clk(clk),
            .rst(rst),
            .level(cmdHigh[p] & cmdLow[p]),
            .held(overlap[p])
         );
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Trip sequencers: channel 0 U overcurrent, 1 W overcurrent, 2 V short.

   reg [1:0] stQ [0:2];
   reg [19:0] cntQ [0:2];
   integer i;

   function [19:0] delayOf;
      input integer ch;
      begin
         delayOf = (ch == 2) ? SC_DELAY : OC_DELAY;
      end
   endfunction

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         for (i = 0; i < 3; i = i + 1) begin
            stQ[i] <= ST_IDLE;
            cntQ[i] <= 20'h00000;
         end
      end else begin
         for (i = 0; i < 3; i = i + 1) begin
            case (stQ[i])
               ST_IDLE: begin
                  if (armed[i]) begin
                     stQ[i] <= ST_DELAY;
                     cntQ[i] <= delayOf(i) - 20'h00001;
                  end
               end
               ST_DELAY: begin
                  if (cntQ[i] == 20'h00000) begin
                     stQ[i] <= ST_HOLD;
                     cntQ[i] <= HOLD_LEN - 20'h00001;
                  end else begin
                     cntQ[i] <= cntQ[i] - 20'h00001;
                  end
               end
               ST_HOLD: begin
                  if (cntQ[i] == 20'h00000) begin
                     stQ[i] <= ST_IDLE;
                  end else begin
                     cntQ[i] <= cntQ[i] - 20'h00001;
                  end
               end
               default: begin
                  stQ[i] <= ST_IDLE;
               end
            endcase
         end
      end
   end

   wire [2:0] tripped = {stQ[2] == ST_HOLD, stQ[1] == ST_HOLD, stQ[0] == ST_HOLD};

   ////////////////////////////////////////////////////////////////////////////
   // Thermal shutdown with hysteresis, index 0 U, 1 W.

   reg [1:0] thermalQ;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         thermalQ <= 2'h0;
      end else begin
         thermalQ <= hotTrip | (thermalQ & hotRelease);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Fault combining and gate drive.

   wire [2:0] ownFault;
   wire [2:0] phaseOff;
   reg [2:0] highQ;
   reg [2:0] lowQ;
   reg [2:0] driveQ;
   // Gates drop on a raw overlap at once; only the fault report waits for the filter.
   wire [2:0] rawOverlap = cmdHigh & cmdLow;

   assign ownFault[0] = tripped[0] | overlap[0] | thermalQ[0];
   assign ownFault[1] = tripped[2] | overlap[1];
   assign ownFault[2] = tripped[1] | overlap[2] | thermalQ[1];

   assign phaseOff[0] = ownFault[0] | ~lineIn[0];
   assign phaseOff[1] = ownFault[1] | lineLowV;
   assign phaseOff[2] = ownFault[2] | ~lineIn[2];

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         highQ <= 3'h0;
         lowQ <= 3'h0;
         driveQ <= 3'h0;
      end else begin
         highQ <= cmdHigh & ~phaseOff & ~rawOverlap;
         lowQ <= cmdLow & ~phaseOff & ~rawOverlap;
         driveQ <= ownFault;
      end
   end

   assign highGateOut = highQ;
   assign lowGateOut = lowQ;
   assign faultLineUOut = 1'b0;
   assign faultLineVOut = 1'b0;
   assign faultLineWOut = 1'b0;
   assign faultLineUOeN = ~driveQ[0];
   assign faultLineVOeN = ~driveQ[1];
   assign faultLineWOeN = ~driveQ[2];

   ////////////////////////////////////////////////////////////////////////////
   // Event capture and register bus.

   wire [8:0] evLevel;
   reg [8:0] evPrevQ;
   reg [8:0] statusQ;
   reg [8:0] maskQ;
   reg ackQ;
   reg [31:0] rdataQ;
   reg [1:0] ownDriveQ;
   wire [8:0] evRise;
   wire [1:0] regSel = address[3:2];
   wire wrAck = ackQ & write;
   wire [8:0] clearBits;

   // An external fault is a low line that no local source explains.
   // The line is seen two cycles late through the synchroniser, so own drive is
   // remembered that long; otherwise each release would look like an external pull.
   assign evLevel = {(~lineIn[0]) & ~(|driveQ) & ~(|ownDriveQ), thermalQ, overlap[2],
      overlap[1], overlap[0], tripped[2], tripped[1], tripped[0]};
   assign evRise = evLevel & ~evPrevQ;
   assign clearBits = (wrAck && regSel == `REG_STATUS) ? writedata[8:0] : 9'h000;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         evPrevQ <= 9'h000;
         ownDriveQ <= 2'h0;
         statusQ <= 9'h000;
         maskQ <= `MASK_RESET;
         ackQ <= 1'b0;
         rdataQ <= 32'h00000000;
      end else begin
         evPrevQ <= evLevel;
         ownDriveQ <= {ownDriveQ[0], |driveQ};
         // A new event in the clearing cycle survives the clear.
         statusQ <= (statusQ & ~clearBits) | evRise;
         if (wrAck && regSel == `REG_MASK) begin
            maskQ <= writedata[8:0];
         end
         ackQ <= (read | write) & ~ackQ;
         if (read & ~ackQ) begin
            case (regSel)
               `REG_STATUS: rdataQ <= {23'h000000, statusQ};
               `REG_MASK: rdataQ <= {23'h000000, maskQ};
               `REG_LIVE: rdataQ <= {23'h000000, evLevel};
               default: rdataQ <= 32'h00000000;
            endcase
         end
      end
   end

   assign waitrequest = (read | write) & ~ackQ;
   assign readdata = rdataQ;
   assign irq = |(statusQ & maskQ);
endmodule

// File: tb/fault_checker.sv
// Port checks for the inverter fault protection block.
`timescale 1ns/1ps
module fault_checker #(
   parameter HOLD_CYCLES = 400000
) (
   // Clock and reset
   input wire clk,
   input wire rst,
   // Inputs watched
   input wire overcurrentSenseU,
   input wire lowsideSenseV,
   input wire [1:0] tempAboveTrip,
   input wire faultLineUIn,
   input wire read,
   input wire write,
   // Outputs watched
   input wire [2:0] highGateOut,
   input wire [2:0] lowGateOut,
   input wire faultLineUOut,
   input wire faultLineVOut,
   input wire faultLineWOut,
   input wire faultLineUOeN,
   input wire faultLineVOeN,
   input wire faultLineWOeN,
   input wire waitrequest
);
   logic [7:0] runU_q, runV_q, lowRun_q;
   function automatic logic [7:0] sat(input logic [7:0] c);
      return c + {7'h00, c != 8'hFF};
   endfunction
   // Whole-cycle run lengths, so a short blip never arms a trip check.
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         runU_q <= 8'h00;
         runV_q <= 8'h00;
         lowRun_q <= 8'h00;
      end else begin
         runU_q <= overcurrentSenseU ? sat(runU_q) : 8'h00;
         runV_q <= lowsideSenseV ? sat(runV_q) : 8'h00;
         lowRun_q <= faultLineUIn ? 8'h00 : sat(lowRun_q);
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////
   chk_oc_trip: assert property (runU_q == 8'h14 |-> ##[1:20] !faultLineUOeN)
      else $error("U overcurrent did not trip");
   chk_sc_trip: assert property (runV_q == 8'h28 |-> ##[1:50] !faultLineVOeN)
      else $error("V short circuit did not trip");
   chk_heat_u: assert property (tempAboveTrip[0] [*8] |-> !faultLineUOeN)
      else $error("U thermal fault missing");
   chk_heat_w: assert property (tempAboveTrip[1] [*8] |-> !faultLineWOeN)
      else $error("W thermal fault missing");
   chk_no_shoot: assert property ((highGateOut & lowGateOut) == 3'h0)
      else $error("both gates of a phase on");
   chk_uw_off: assert property (
      lowRun_q >= 8'h06 |-> ((highGateOut | lowGateOut) & 3'h5) == 3'h0)
      else $error("U or W gate on while line low");
   chk_v_off: assert property (lowRun_q >= 8'h14 |-> !highGateOut[1] && !lowGateOut[1])
      else $error("V gate on while line low");
   chk_drain_low: assert property ({faultLineUOut, faultLineVOut, faultLineWOut} == 3'h0)
      else $error("fault pin drives high");
   chk_bus_wait: assert property ((read || write) && waitrequest |=> !waitrequest)
      else $error("bus answer late");
endmodule
bind inverter_fault_protection fault_checker #(.HOLD_CYCLES(HOLD_CYCLES)) checker_i (
   .clk, .rst, .overcurrentSenseU, .lowsideSenseV, .tempAboveTrip, .faultLineUIn, .read,
   .write, .highGateOut, .lowGateOut, .faultLineUOut, .faultLineVOut, .faultLineWOut,
   .faultLineUOeN, .faultLineVOeN, .faultLineWOeN, .waitrequest);

// File: tb/mcu_model.sv
// Controller model that issues commands and reacts to the fault wire.
`timescale 1ns/1ps
module mcu_model #(
   parameter int RESUME = 40
) (
   // Clock, reset and fault wire
   input wire logic clk,
   input wire logic rst,
   input wire logic faultWire,
   // Wanted commands and reaction switch
   input wire logic [2:0] wantHigh,
   input wire logic [2:0] wantLow,
   input wire logic obey,
   // Commands to the block
   output logic [2:0] highCmd,
   output logic [2:0] lowCmd
);
   int quiet_q;
   ////////////////////////////////////////////////////////////
   // drop, wait, pass
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         quiet_q <= 0;
         highCmd <= 3'h0;
         lowCmd <= 3'h0;
      end else if (obey && (!faultWire || quiet_q > 0)) begin
         quiet_q <= faultWire ? quiet_q - 1 : RESUME;
         highCmd <= 3'h0;
         lowCmd <= 3'h0;
      end else begin
         highCmd <= wantHigh;
         lowCmd <= wantLow;
      end
   end
endmodule

// File: tb/inverter_fault_protection_bench.sv
// Self-checking bench for the inverter fault protection block.
`timescale 1ns/1ps
module inverter_fault_protection_bench;
   localparam int HOLD = 200;
   logic clk = 1'b0, rst = 1'b1, obey = 1'b1, extOeN = 1'b1, read = 1'b0, write = 1'b0;
   logic [2:0] sense = 3'h0, wantHigh = 3'h7, wantLow = 3'h0, highCmd, lowCmd, hiG, loG;
   logic [1:0] tTrip = 2'h0, tRel = 2'h0;
   logic [3:0] address = 4'h0;
   logic [31:0] writedata = 32'h0, readdata, rdata;
   logic waitrequest, irq, oU, oV, oW;
   wire [3:0] oen = {oU & oV & oW & extOeN, oW, oV, oU};
   int n_errors = 0, checks = 0, cyc = 0;
   always #12.5 clk = ~clk;
   inverter_fault_protection #(.HOLD_CYCLES(HOLD)) DUT (
      .clk(clk), .rst(rst), .overcurrentSenseU(sense[0]), .overcurrentSenseW(sense[2]),
      .lowsideSenseV(sense[1]), .tempAboveTrip(tTrip), .tempAboveRelease(tRel),
      .highCommandIn(highCmd), .lowCommandIn(lowCmd), .highGateOut(hiG), .lowGateOut(loG),
      .faultLineUIn(oen[3]), .faultLineVIn(oen[3]), .faultLineWIn(oen[3]),
      .faultLineUOut(), .faultLineVOut(), .faultLineWOut(),
      .faultLineUOeN(oU), .faultLineVOeN(oV), .faultLineWOeN(oW), .address(address),
      .read(read), .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .irq(irq));
   mcu_model #(.RESUME(40)) host (.clk(clk), .rst(rst), .faultWire(oen[3]),
      .wantHigh(wantHigh), .wantLow(wantLow), .obey(obey), .highCmd(highCmd), .lowCmd(lowCmd));
   ////////////////////////////////////////////////////////////
   task stop_test;
      if (n_errors == 0 && checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 10000) begin
         n_errors++;
         stop_test();
      end
   end
   task chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task wcyc(input int i, input logic v, output int n);
      n = 0;
      do begin @(posedge clk); n++; end while (oen[i] !== v && n < 2000);
   endtask
   // Holds the request until waitrequest is sampled low at a rising edge.
   task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
      int n;
      n = 0;
      address <= a;
      writedata <= d;
      read <= ~wr;
      write <= wr;
      do begin @(posedge clk); n++; end while (waitrequest !== 1'b0);
      rdata = readdata;
      read <= 1'b0;
      write <= 1'b0;
      chk(n < 50, 1'b1);
      @(posedge clk);
   endtask
   ////////////////////////////////////////////////////////////
   task trip(input int i);
      int n, lat, ev;
      lat = (i == 1) ? 69 : 27;
      ev = (i == 1) ? 2 : i / 2;
      sense[i] <= 1'b1;
      repeat (lat / 3) @(posedge clk);
      sense[i] <= 1'b0;
      repeat (100) @(posedge clk);
      chk(oen[i], 1'b1);
      sense[i] <= 1'b1;
      wcyc(i, 1'b0, n);
      sense[i] <= 1'b0;
      chk(n >= lat + 1 && n <= lat + 5, 1'b1);
      wcyc(i, 1'b1, n);
      chk(n >= HOLD - 1 && n <= HOLD + 1, 1'b1);
      chk(irq, 1'b1);
      bus(1'b0, 4'h0, 32'h0);
      chk(rdata[ev], 1'b1);
      bus(1'b1, 4'h0, 32'h1FF);
      bus(1'b0, 4'h0, 32'h0);
      chk({irq, rdata[30:0]}, 32'h0);
      repeat (60) @(posedge clk);
      chk(hiG, 3'h7);
   endtask
   task overlap;
      int n;
      obey <= 1'b0;
      wantLow <= 3'h1;
      repeat (20) @(posedge clk);
      wantLow <= 3'h0;
      repeat (40) @(posedge clk);
      chk(oen[0], 1'b1);
      wantLow <= 3'h1;
      wcyc(0, 1'b0, n);
      chk(n >= 33 && n <= 40, 1'b1);
      repeat (50) @(posedge clk);
      chk({oen[0], hiG[0], loG[0]}, 3'h0);
      wantLow <= 3'h0;
      wcyc(0, 1'b1, n);
      chk(n <= 7, 1'b1);
      repeat (8) @(posedge clk);
      chk(hiG, 3'h7);
      obey <= 1'b1;
   endtask
   task heat(input int j);
      int n;
      tTrip[j] <= 1'b1;
      tRel[j] <= 1'b1;
      wcyc(j * 2, 1'b0, n);
      chk(n <= 8, 1'b1);
      repeat (4) @(posedge clk);
      tTrip[j] <= 1'b0;
      repeat (30) @(posedge clk);
      chk(oen[j * 2], 1'b0);
      tRel[j] <= 1'b0;
      wcyc(j * 2, 1'b1, n);
      chk(n <= 8, 1'b1);
      repeat (60) @(posedge clk);
      chk(hiG, 3'h7);
   endtask
   task ext;
      obey <= 1'b0;
      extOeN <= 1'b0;
      repeat (120) @(posedge clk);
      chk({hiG, loG}, 6'h0);
      chk(oen[2:0], 3'h7);
      bus(1'b0, 4'h0, 32'h0);
      chk(rdata[8], 1'b1);
      bus(1'b1, 4'h0, 32'h1FF);
      extOeN <= 1'b1;
      repeat (120) @(posedge clk);
      chk(hiG, 3'h7);
      obey <= 1'b1;
   endtask
   ////////////////////////////////////////////////////////////
   initial begin
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      repeat (4) @(posedge clk);
      bus(1'b0, 4'h4, 32'h0);
      chk(rdata, 32'h0);
      bus(1'b0, 4'hC, 32'h0);
      chk(rdata, 32'h0);
      bus(1'b1, 4'h4, 32'h1FF);
      repeat (10) @(posedge clk);
      chk(hiG, 3'h7);
      overlap();
      heat(0);
      heat(1);
      ext();
      for (int i = 0; i < 3; i++) trip(i);
      stop_test();
   end
endmodule
